// ===== rsd_defs.svh
// Notes on behaviour
// - Minimum-speed choice applies only with the sensor source; encoder ignores it.
// - Encoder source always waits at most one second for a pulse.
// - Five minimum-speed choices wait 1, 1.5, 3, 5 or 7.5 seconds.
// - Last speed holds until the wait limit passes, then speed reads zero.
// - With stop mode off, zero only after the full wait limit.
// - Stop mode 2, 4 or 8 zeroes after that multiple of last period, if shorter than the wait limit.
// - Moving average over 2 to 999 samples, or off.
// - Display-only average over 0.5, 1 or 2 seconds; other outputs untouched.
// - Pulses per turn: 1 or 4 for sensor, 1 to 4000 for encoder.
`ifndef RSD_DEFS_SVH
`define RSD_DEFS_SVH
// Register offsets
`define RSD_OFF_CTRL 8'h00
`define RSD_OFF_PPR 8'h04
`define RSD_OFF_MAVG 8'h08
`define RSD_OFF_PERIOD 8'h0C
`define RSD_OFF_SPEED 8'h10
`define RSD_OFF_AVG 8'h14
`define RSD_OFF_DISP 8'h18
`define RSD_OFF_STATUS 8'h1C
// Control fields
`define RSD_CTRL_SRC 0
`define RSD_CTRL_MIN_LSB 1
`define RSD_CTRL_MIN_MSB 3
`define RSD_CTRL_STOP_LSB 4
`define RSD_CTRL_STOP_MSB 5
`define RSD_CTRL_DISP_LSB 6
`define RSD_CTRL_DISP_MSB 7
// Reset values and limits
`define RSD_PPR_RST 12'h001
`define RSD_PPR_LO 12'h001
`define RSD_PPR_HI 12'h004
`define RSD_PPR_ENC_MAX 12'hFA0
`define RSD_MAVG_RST 10'h000
`define RSD_MAVG_MIN 10'h002
`define RSD_MAVG_MAX 10'h3E7
// Times
`define RSD_CLK_HZ 40000000
`define RSD_WAIT_A_MS 1000
`define RSD_WAIT_B_MS 1500
`define RSD_WAIT_C_MS 3000
`define RSD_WAIT_D_MS 5000
`define RSD_WAIT_E_MS 7500
`define RSD_TICK_US 1000
`define RSD_DISP_L_MS 500
`define RSD_DISP_M_MS 1000
`define RSD_DISP_H_MS 2000
// Tenths of rpm per pulse-per-second
`define RSD_TENTHS_PER_MIN 600
`endif

// ===== rsd_divider.sv
`timescale 1ns/1ps
module rsd_divider import rsd_pkg::*; #(
   parameter int W = 40
) (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic start,
   input wire logic [W-1:0] num,
   input wire logic [W-1:0] den,
   output logic busy,
   output logic done,
   output logic [W-1:0] quot
);
   typedef struct packed {
      logic [W:0] rem;
      logic [W-1:0] quo;
      logic [W-1:0] den;
      logic [6:0] left;
      logic busy;
      logic done;
   } rsd_div_t;
   rsd_div_t st, next_st;
   logic [W:0] trial;

   // One quotient bit per cycle, restoring
   always_comb begin
      next_st = st;
      next_st.done = 1'b0;
      trial = {st.rem[W-1:0], st.quo[W-1]};
      if (st.busy) begin
         next_st.quo = {st.quo[W-2:0], 1'b0};
         if (trial >= {1'b0, st.den}) begin
            next_st.rem = trial - {1'b0, st.den};
            next_st.quo[0] = 1'b1;
         end else begin
            next_st.rem = trial;
         end
         next_st.left = st.left - 7'h01;
         if (st.left == 7'h01) begin
            next_st.busy = 1'b0;
            next_st.done = 1'b1;
         end
      end else if (start) begin
         next_st.rem = '0;
         next_st.quo = num;
         next_st.den = den;
         next_st.left = 7'(W);
         next_st.busy = 1'b1;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign busy = st.busy;
   assign done = st.done;
   assign quot = st.quo;
endmodule

// ===== rsd_pkg.sv
package rsd_pkg;
   typedef enum logic {RSD_SRC_SENSOR = 1'h0, RSD_SRC_ENCODER = 1'h1} rsd_src_t;
   typedef enum logic [1:0] {
      RSD_STOP_OFF = 2'h0, RSD_STOP_X2 = 2'h1, RSD_STOP_X4 = 2'h2, RSD_STOP_X8 = 2'h3
   } rsd_stop_t;
   typedef enum logic [1:0] {
      RSD_DISP_OFF = 2'h0, RSD_DISP_L = 2'h1, RSD_DISP_M = 2'h2, RSD_DISP_H = 2'h3
   } rsd_disp_t;
endpackage

// ===== rsd_pulse_gen.sv
`timescale 1ns/1ps
module rsd_pulse_gen (
   input wire logic core_clk,
   input wire logic run,
   input wire logic [15:0] gap,
   output logic pulse
);
   logic [15:0] cnt = 16'h0000;
   initial pulse = 1'b0;
   // Rising edge every gap cycles, two cycles high, idle low
   always @(posedge core_clk) begin
      if (!run) begin
         cnt <= 16'h0000;
         pulse <= 1'b0;
      end else begin
         cnt <= (cnt == gap - 16'h0001) ? 16'h0000 : cnt + 16'h0001;
         pulse <= (cnt < 16'h0002);
      end
   end
endmodule

// ===== rsd_speed_detect.sv
`timescale 1ns/1ps
`include "rsd_defs.svh"
module rsd_speed_detect import rsd_pkg::*; #(
   parameter int CLK_HZ = `RSD_CLK_HZ,
   parameter int unsigned WAIT_A_CYC = `RSD_WAIT_A_MS * (`RSD_CLK_HZ / 1000),
   parameter int unsigned WAIT_B_CYC = `RSD_WAIT_B_MS * (`RSD_CLK_HZ / 1000),
   parameter int unsigned WAIT_C_CYC = `RSD_WAIT_C_MS * (`RSD_CLK_HZ / 1000),
   parameter int unsigned WAIT_D_CYC = `RSD_WAIT_D_MS * (`RSD_CLK_HZ / 1000),
   parameter int unsigned WAIT_E_CYC = `RSD_WAIT_E_MS * (`RSD_CLK_HZ / 1000),
   parameter int unsigned TICK_CYC = `RSD_TICK_US * (`RSD_CLK_HZ / 1000000),
   parameter int MAVG_DEPTH = 1024
) (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic sensorPulse,
   input wire logic encoderPulse,
   input wire logic [7:0] regAddr,
   input wire logic [31:0] regWdata,
   input wire logic regWr,
   input wire logic regRd,
   output logic [31:0] regRdata,
   output logic [23:0] speedRaw,
   output logic [23:0] speedAvg,
   output logic [23:0] speedDisp,
   output logic stopped
);
   localparam logic [39:0] SPD_NUM = 40'(64'(`RSD_TENTHS_PER_MIN) * 64'(CLK_HZ));
   localparam int TPMS = 1000 / `RSD_TICK_US;
   localparam logic [11:0] WIN_L = 12'(`RSD_DISP_L_MS * TPMS);
   localparam logic [11:0] WIN_M = 12'(`RSD_DISP_M_MS * TPMS);
   localparam logic [11:0] WIN_H = 12'(`RSD_DISP_H_MS * TPMS);

   typedef struct packed {
      rsd_src_t src;
      logic [2:0] minSel;
      rsd_stop_t stop;
      rsd_disp_t disp;
      logic [11:0] ppr;
      logic [9:0] mavgLen;
      logic pulsePrev;
      logic havePrev;
      logic [31:0] cnt;
      logic [31:0] period;
      logic stopped;
      logic [23:0] speedRaw;
      logic rawValid;
      logic [9:0] wrPtr;
      logic [9:0] fill;
      logic [33:0] sum;
      logic avgPend;
      logic [23:0] speedAvg;
      logic [15:0] tickCnt;
      logic [11:0] dCnt;
      logic [35:0] dSum;
      logic dPend;
      logic [23:0] speedDisp;
      logic [31:0] rdata;
   } rsd_state_t;
   rsd_state_t st, next_st;

   logic [23:0] mem [MAVG_DEPTH];
   logic memWe, pulseSel, edgeSeen, timeoutHit, mavgOn, tick, pprOk;
   logic [31:0] maxWait, limit;
   logic [34:0] periodX;
   logic [11:0] pprEff, win;
   logic [43:0] prod;
   logic [23:0] oldest;
   logic spdStart, spdBusy, spdDone, avgStart, avgBusy, avgDone, dStart, dBusy, dDone;
   logic [39:0] spdQuot;
   logic [33:0] avgQuot;
   logic [35:0] dQuot;

   // Pulse source, edge and wait limit
   always_comb begin
      pulseSel = (st.src == RSD_SRC_ENCODER) ? encoderPulse : sensorPulse;
      edgeSeen = pulseSel && !st.pulsePrev;
      if (st.src == RSD_SRC_ENCODER) begin
         maxWait = WAIT_A_CYC;
      end else begin
         case (st.minSel)
            3'h0: maxWait = WAIT_A_CYC;
            3'h1: maxWait = WAIT_B_CYC;
            3'h2: maxWait = WAIT_C_CYC;
            3'h3: maxWait = WAIT_D_CYC;
            default: maxWait = WAIT_E_CYC;
         endcase
      end
      periodX = {3'h0, st.period} << st.stop;
      if (st.stop != RSD_STOP_OFF && st.period != 32'h0 && periodX < 35'(maxWait)) begin
         limit = periodX[31:0];
      end else begin
         limit = maxWait;
      end
      timeoutHit = st.havePrev && (st.cnt >= limit - 32'h1);
      pprEff = st.ppr;
      if (st.src == RSD_SRC_SENSOR) begin
         pprEff = (st.ppr == `RSD_PPR_HI) ? `RSD_PPR_HI : `RSD_PPR_LO;
      end
      prod = (st.cnt + 32'h1) * pprEff;
      mavgOn = st.mavgLen >= `RSD_MAVG_MIN;
      oldest = mem[st.wrPtr - st.mavgLen];
      tick = st.tickCnt == 16'(TICK_CYC - 1);
      case (st.disp)
         RSD_DISP_L: win = WIN_L;
         RSD_DISP_M: win = WIN_M;
         default: win = WIN_H;
      endcase
      if (st.src == RSD_SRC_ENCODER) begin
         pprOk = regWdata[11:0] >= `RSD_PPR_LO && regWdata[11:0] <= `RSD_PPR_ENC_MAX;
      end else begin
         pprOk = regWdata[11:0] == `RSD_PPR_LO || regWdata[11:0] == `RSD_PPR_HI;
      end
      pprOk = pprOk && regWdata[31:12] == 20'h0;
   end

   assign spdStart = edgeSeen && st.havePrev && !spdBusy;
   assign avgStart = st.avgPend && !avgBusy;
   assign dStart = st.dPend && !dBusy;

   // Next state
   always_comb begin
      next_st = st;
      next_st.rawValid = 1'b0;
      next_st.pulsePrev = pulseSel;
      memWe = 1'b0;
      // Speed result, then period counting; a timeout overrides
      if (spdDone) begin
         next_st.speedRaw = (spdQuot[39:24] != 16'h0) ? 24'hFFFFFF : spdQuot[23:0];
         next_st.stopped = 1'b0;
         next_st.rawValid = 1'b1;
      end
      if (edgeSeen) begin
         next_st.havePrev = 1'b1;
         next_st.cnt = '0;
         if (st.havePrev) begin
            next_st.period = st.cnt + 32'h1;
         end
      end else if (timeoutHit) begin
         next_st.havePrev = 1'b0;
         next_st.cnt = '0;
         next_st.stopped = 1'b1;
         next_st.speedRaw = '0;
         next_st.rawValid = 1'b1;
      end else if (st.havePrev) begin
         next_st.cnt = st.cnt + 32'h1;
      end
      // Moving average; a sample that lands with a start re-arms the divider
      if (avgStart) begin
         next_st.avgPend = 1'b0;
      end
      if (st.rawValid) begin
         if (!mavgOn) begin
            next_st.speedAvg = st.speedRaw;
         end else begin
            memWe = 1'b1;
            next_st.sum = st.sum + 34'(st.speedRaw)
                        - ((st.fill == st.mavgLen) ? 34'(oldest) : 34'h0);
            if (st.fill != st.mavgLen) begin
               next_st.fill = st.fill + 10'h001;
            end
            next_st.wrPtr = st.wrPtr + 10'h001;
            next_st.avgPend = 1'b1;
         end
      end
      if (avgDone && mavgOn) begin
         next_st.speedAvg = avgQuot[23:0];
      end
      // Display average on a 1 ms tick
      next_st.tickCnt = tick ? 16'h0 : st.tickCnt + 16'h1;
      if (st.disp == RSD_DISP_OFF) begin
         next_st.speedDisp = st.speedAvg;
      end else if (tick && !st.dPend) begin
         next_st.dSum = st.dSum + 36'(st.speedAvg);
         next_st.dCnt = st.dCnt + 12'h001;
         next_st.dPend = (st.dCnt + 12'h001) == win;
      end
      if (dStart) begin
         next_st.dPend = 1'b0;
         next_st.dSum = '0;
         next_st.dCnt = '0;
      end
      if (dDone && st.disp != RSD_DISP_OFF) begin
         next_st.speedDisp = dQuot[23:0];
      end
      // Register writes
      if (regWr) begin
         case (regAddr)
            `RSD_OFF_CTRL: begin
               next_st.src = rsd_src_t'(regWdata[`RSD_CTRL_SRC]);
               next_st.minSel = regWdata[`RSD_CTRL_MIN_MSB:`RSD_CTRL_MIN_LSB];
               next_st.stop = rsd_stop_t'(regWdata[`RSD_CTRL_STOP_MSB:`RSD_CTRL_STOP_LSB]);
               next_st.disp = rsd_disp_t'(regWdata[`RSD_CTRL_DISP_MSB:`RSD_CTRL_DISP_LSB]);
               next_st.dSum = '0;
               next_st.dCnt = '0;
               next_st.dPend = 1'b0;
            end
            `RSD_OFF_PPR: if (pprOk) next_st.ppr = regWdata[11:0];
            `RSD_OFF_MAVG: begin
               if (regWdata[31:10] == 22'h0 && regWdata[9:0] <= `RSD_MAVG_MAX) begin
                  next_st.mavgLen = regWdata[9:0];
                  next_st.fill = '0;
                  next_st.sum = '0;
                  next_st.wrPtr = '0;
               end
            end
            default: ;
         endcase
      end
      // Register reads, data in the next cycle
      next_st.rdata = '0;
      if (regRd) begin
         case (regAddr)
            `RSD_OFF_CTRL: next_st.rdata = {24'h0, st.disp, st.stop, st.minSel, st.src};
            `RSD_OFF_PPR: next_st.rdata = {20'h0, st.ppr};
            `RSD_OFF_MAVG: next_st.rdata = {22'h0, st.mavgLen};
            `RSD_OFF_PERIOD: next_st.rdata = st.period;
            `RSD_OFF_SPEED: next_st.rdata = {8'h0, st.speedRaw};
            `RSD_OFF_AVG: next_st.rdata = {8'h0, st.speedAvg};
            `RSD_OFF_DISP: next_st.rdata = {8'h0, st.speedDisp};
            `RSD_OFF_STATUS: next_st.rdata = {31'h0, st.stopped};
            default: next_st.rdata = '0;
         endcase
      end
   end

   // State register
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         st <= '0;
         st.ppr <= `RSD_PPR_RST;
         st.mavgLen <= `RSD_MAVG_RST;
         st.stopped <= 1'b1;
      end else begin
         st <= next_st;
      end
   end

   // Sample store for the moving average
   always_ff @(posedge core_clk) begin
      if (memWe) begin
         mem[st.wrPtr] <= st.speedRaw;
      end
   end

   rsd_divider #(.W(40)) u_spd_div (
      .core_clk(core_clk), .rst_n(rst_n), .start(spdStart), .num(SPD_NUM),
      .den(prod[39:0]), .busy(spdBusy), .done(spdDone), .quot(spdQuot)
   );
   rsd_divider #(.W(34)) u_avg_div (
      .core_clk(core_clk), .rst_n(rst_n), .start(avgStart), .num(st.sum),
      .den({24'h0, st.fill}), .busy(avgBusy), .done(avgDone), .quot(avgQuot)
   );
   rsd_divider #(.W(36)) u_disp_div (
      .core_clk(core_clk), .rst_n(rst_n), .start(dStart), .num(st.dSum),
      .den({24'h0, st.dCnt}), .busy(dBusy), .done(dDone), .quot(dQuot)
   );

   assign regRdata = st.rdata;
   assign speedRaw = st.speedRaw;
   assign speedAvg = st.speedAvg;
   assign speedDisp = st.speedDisp;
   assign stopped = st.stopped;

   // Checks
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   sequence s_timeout;
      timeoutHit && !edgeSeen;
   endsequence
   a_enc_wait_fixed: assert property (st.src == RSD_SRC_ENCODER && timeoutHit
      && st.stop == RSD_STOP_OFF |-> st.cnt == WAIT_A_CYC - 1) else $error("enc wait not 1 s");
   a_wait_table: assert property (st.src == RSD_SRC_SENSOR && st.minSel == 3'h1
      && st.stop == RSD_STOP_OFF && timeoutHit |-> st.cnt == WAIT_B_CYC - 1)
      else $error("wait choice wrong");
   a_full_wait_off: assert property (st.src == RSD_SRC_SENSOR && st.minSel == 3'h4
      && st.stop == RSD_STOP_OFF && timeoutHit |-> st.cnt == WAIT_E_CYC - 1)
      else $error("stop-off wait wrong");
   a_zero_at_wait: assert property (s_timeout |=> speedRaw == 24'h0 && stopped
      ##1 $stable(stopped)) else $error("no zero after wait");
   a_hold_last: assert property (st.havePrev && !timeoutHit && !spdDone
      |=> $stable(speedRaw)) else $error("speed changed while waiting");
   a_stop_mult: assert property (st.stop == RSD_STOP_X4 && st.period != 32'h0
      && periodX < 35'(maxWait) && timeoutHit |-> st.cnt == {st.period[29:0], 2'b00} - 32'h1)
      else $error("stop multiple wrong");
   a_mavg_off: assert property (st.rawValid && !mavgOn |=> speedAvg == $past(speedRaw))
      else $error("avg not bypassed");
   a_disp_off: assert property (st.disp == RSD_DISP_OFF && $past(st.disp) == RSD_DISP_OFF
      |=> speedDisp == $past(speedAvg)) else $error("display not bypassed");
   a_ppr_guard: assert property (regWr && regAddr == `RSD_OFF_PPR
      && st.src == RSD_SRC_SENSOR && regWdata != 32'h1 && regWdata != 32'h4
      |=> $stable(st.ppr)) else $error("bad ppr taken");
   a_period_cap: assert property (edgeSeen && st.havePrev
      |=> st.period == $past(st.cnt) + 1) else $error("period capture wrong");
endmodule

// ===== rsd_speed_detect_tb.sv
`timescale 1ns/1ps
`include "rsd_defs.svh"
`define CHK(g, e) begin numChecks++; if ((g) !== (e)) begin fails++; \
   $display("BAD t=%0t got %0h exp %0h", $time, g, e); end end
module rsd_speed_detect_tb;
   localparam int W[5] = '{1200, 1800, 3600, 6000, 9000};
   localparam int TICK = 4;
   localparam longint K = 64'(`RSD_TENTHS_PER_MIN) * `RSD_CLK_HZ;
   localparam logic [23:0] S4 = 24'h5B8D80;
   logic core_clk = 1'b0;
   logic rst_n = 1'b0;
   logic regWr = 1'b0;
   logic regRd = 1'b0;
   logic [7:0] regAddr = 8'h00;
   logic [31:0] regWdata = 32'h0;
   logic runS = 1'b0;
   logic runE = 1'b0;
   logic selSrc = 1'b0;
   logic prevP = 1'b0;
   logic [15:0] gapV = 16'h03E8;
   logic sensorPulse, encoderPulse, stopped;
   logic [31:0] regRdata;
   logic [23:0] speedRaw, speedAvg, speedDisp;
   int fails = 0, numChecks = 0, cycles = 0, sinceEdge = 0;

   // Clock
   always #12.5 core_clk = ~core_clk;

   rsd_pulse_gen i_rsd_pulse_gen (.core_clk(core_clk), .run(runS), .gap(gapV),
      .pulse(sensorPulse));
   rsd_pulse_gen i_rsd_pulse_gen_enc (.core_clk(core_clk), .run(runE), .gap(gapV),
      .pulse(encoderPulse));

   rsd_speed_detect #(.WAIT_A_CYC(W[0]), .WAIT_B_CYC(W[1]), .WAIT_C_CYC(W[2]),
      .WAIT_D_CYC(W[3]), .WAIT_E_CYC(W[4]), .TICK_CYC(TICK)) i_rsd_speed_detect (
      .core_clk(core_clk), .rst_n(rst_n), .sensorPulse(sensorPulse),
      .encoderPulse(encoderPulse), .regAddr(regAddr), .regWdata(regWdata),
      .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .speedRaw(speedRaw),
      .speedAvg(speedAvg), .speedDisp(speedDisp), .stopped(stopped));

   // Cycles since last edge of the selected source; run ceiling
   always @(posedge core_clk) begin
      prevP <= selSrc ? encoderPulse : sensorPulse;
      sinceEdge <= ((selSrc ? encoderPulse : sensorPulse) && !prevP) ? 0 : sinceEdge + 1;
      cycles <= cycles + 1;
      if (cycles == 99000) begin
         fails++;
         give_verdict();
      end
   end

   task automatic give_verdict();
      $display("TB: checks %0d, mismatches %0d", numChecks, fails);
      if (fails == 0 && numChecks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge core_clk);
      regWr <= 1'b1;
      regAddr <= a;
      regWdata <= d;
      @(posedge core_clk);
      regWr <= 1'b0;
   endtask

   task automatic chk_reg(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] d;
      @(posedge core_clk);
      regRd <= 1'b1;
      regAddr <= a;
      @(posedge core_clk);
      regRd <= 1'b0;
      #1 d = regRdata;
      `CHK(d, e)
   endtask

   function automatic logic [31:0] mk(input logic s, input logic [2:0] m,
      input logic [1:0] st, input logic [1:0] dp);
      return {24'h0, dp, st, m, s};
   endfunction

   // Spin up, stop the source, time the fall to zero
   task automatic trial(input logic [31:0] c, input logic [11:0] p, input int lim);
      logic [23:0] held, e;
      int n;
      e = 24'(K / (longint'(gapV) * p));
      wr(`RSD_OFF_CTRL, c);
      selSrc <= c[0];
      wr(`RSD_OFF_PPR, {20'h0, p});
      runS <= !c[0];
      runE <= c[0];
      repeat (2 * gapV + 100) @(posedge core_clk);
      chk_reg(`RSD_OFF_PPR, {20'h0, p});
      chk_reg(`RSD_OFF_PERIOD, {16'h0, gapV});
      `CHK(speedRaw, e)
      chk_reg(`RSD_OFF_SPEED, {8'h0, e});
      @(posedge core_clk);
      runS <= 1'b0;
      runE <= 1'b0;
      n = 0;
      held = speedRaw;
      while (stopped !== 1'b1 && n < 20000) begin
         held = speedRaw;
         n++;
         @(posedge core_clk);
      end
      `CHK(held, e)
      `CHK(speedRaw, 24'h0)
      `CHK(sinceEdge > lim - 3 && sinceEdge < lim + 5, 1'b1)
      repeat (60) @(posedge core_clk);
      `CHK(speedAvg, e / 2)
      chk_reg(`RSD_OFF_AVG, {8'h0, e >> 1});
   endtask

   // Main sequence
   initial begin
      repeat (4) @(posedge core_clk);
      rst_n <= 1'b1;
      `CHK(stopped, 1'b1)
      chk_reg(`RSD_OFF_CTRL, 32'h0);
      chk_reg(`RSD_OFF_PPR, 32'h1);
      chk_reg(`RSD_OFF_MAVG, 32'h0);
      chk_reg(`RSD_OFF_STATUS, 32'h1);
      wr(8'h20, 32'hFF);
      chk_reg(8'h20, 32'h0);
      wr(`RSD_OFF_PPR, 32'h3);
      chk_reg(`RSD_OFF_PPR, 32'h1);
      wr(`RSD_OFF_MAVG, 32'h3E8);
      chk_reg(`RSD_OFF_MAVG, 32'h0);
      wr(`RSD_OFF_MAVG, 32'h2);
      chk_reg(`RSD_OFF_MAVG, 32'h2);
      for (int m = 0; m < 5; m++) begin
         trial(mk(1'b0, 3'(m), 2'h0, 2'h0), 12'h004, W[m]);
      end
      for (int s = 1; s < 4; s++) begin
         trial(mk(1'b0, 3'h4, 2'(s), 2'h0), 12'h004, int'(gapV) << s);
      end
      trial(mk(1'b1, 3'h4, 2'h0, 2'h0), 12'hFA0, W[0]);
      wr(`RSD_OFF_PPR, 32'hFA1);
      chk_reg(`RSD_OFF_PPR, 32'hFA0);
      wr(`RSD_OFF_MAVG, 32'h0);
      wr(`RSD_OFF_CTRL, mk(1'b0, 3'h0, 2'h0, 2'h0));
      selSrc <= 1'b0;
      wr(`RSD_OFF_PPR, 32'h4);
      runS <= 1'b1;
      for (int m = 1; m < 4; m++) begin
         repeat (2200) @(posedge core_clk);
         wr(`RSD_OFF_CTRL, mk(1'b0, 3'h0, 2'h0, 2'(m)));
         repeat (TICK * (250 << m) + 100) @(posedge core_clk);
         `CHK(speedDisp, S4)
         chk_reg(`RSD_OFF_DISP, {8'h0, S4});
         runS <= 1'b0;
         repeat (1300) @(posedge core_clk);
         `CHK(speedRaw, 24'h0)
         `CHK(speedDisp, S4)
         repeat (TICK * (250 << m) - 1300) @(posedge core_clk);
         `CHK(speedDisp > 24'h0 && speedDisp < S4, 1'b1)
         runS <= 1'b1;
      end
      give_verdict();
   end
endmodule
